/* File: logic/add_family_pkg.sv */
package add_family_pkg;

  // opcode group codes in bits 15..12
  localparam logic [3:0] GRP_BCD       = 4'hC;
  localparam logic [3:0] GRP_ADD       = 4'hD;
  localparam logic [3:0] GRP_IMM       = 4'h0;
  localparam logic [3:0] IMM_SUBCODE   = 4'h6;  // bits 11..8 of the immediate add
  localparam logic [3:0] BCD_ZERO_BITS = 4'h0;  // bits 7..4 of the bcd add

  // operation selector codes
  localparam logic [2:0] SEL_EA_TO_REG_B = 3'h0;
  localparam logic [2:0] SEL_EA_TO_REG_W = 3'h1;
  localparam logic [2:0] SEL_EA_TO_REG_L = 3'h2;
  localparam logic [2:0] SEL_AREG_W      = 3'h3;
  localparam logic [2:0] SEL_REG_TO_EA_B = 3'h4;
  localparam logic [2:0] SEL_REG_TO_EA_W = 3'h5;
  localparam logic [2:0] SEL_REG_TO_EA_L = 3'h6;
  localparam logic [2:0] SEL_AREG_L      = 3'h7;

  // operand sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // effective address modes
  localparam logic [2:0] EA_DREG  = 3'h0;
  localparam logic [2:0] EA_AREG  = 3'h1;
  localparam logic [2:0] EA_IND   = 3'h2;
  localparam logic [2:0] EA_POST  = 3'h3;
  localparam logic [2:0] EA_PRE   = 3'h4;
  localparam logic [2:0] EA_DISP  = 3'h5;
  localparam logic [2:0] EA_INDEX = 3'h6;
  localparam logic [2:0] EA_EXT   = 3'h7;
  // register field values under mode 111
  localparam logic [2:0] EXT_ABS_W  = 3'h0;
  localparam logic [2:0] EXT_ABS_L  = 3'h1;
  localparam logic [2:0] EXT_PC_D   = 3'h2;
  localparam logic [2:0] EXT_PC_X   = 3'h3;
  localparam logic [2:0] EXT_IMM    = 3'h4;

  // operation kinds reported on the decode port
  typedef enum logic [4:0] {
    OP_NONE  = 5'h01,
    OP_BCD   = 5'h02,
    OP_BIN   = 5'h04,
    OP_AREG  = 5'h08,
    OP_IMM   = 5'h10
  } op_e;

  // flag bit positions in the five-bit condition field
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_X = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

endpackage

/* File: logic/add_ea_check.sv */
`timescale 1ns/1ps
`default_nettype none
// classifies an effective address field against the three allowed sets
module add_ea_check (
  input  wire logic [2:0] mode,
  input  wire logic [2:0] reg_no,
  output logic            ok_any,
  output logic            ok_mem_alt,
  output logic            ok_data_alt
);
  import add_family_pkg::*;

  logic ext_abs;
  logic ext_all;

  // absolute forms and every legal mode 111 form
  assign ext_abs = (mode == EA_EXT) && (reg_no == EXT_ABS_W || reg_no == EXT_ABS_L);
  assign ext_all = (mode == EA_EXT) && (reg_no <= EXT_IMM);

  // source side takes every mode
  assign ok_any = (mode != EA_EXT) || ext_all;
  // memory alterable: 010..110 and absolute
  assign ok_mem_alt = ((mode >= EA_IND) && (mode <= EA_INDEX)) || ext_abs;
  // data alterable adds data register direct
  assign ok_data_alt = ok_mem_alt || (mode == EA_DREG);

endmodule // add_ea_check
`default_nettype wire

/* File: logic/add_bcd_byte.sv */
`timescale 1ns/1ps
`default_nettype none
// packed bcd byte adder with extend input
module add_bcd_byte (
  input  wire logic [7:0] src,
  input  wire logic [7:0] dst,
  input  wire logic       x_in,
  output logic [7:0]      sum,
  output logic            carry
);

  logic [4:0] lo_raw;
  logic [4:0] lo_fix;
  logic       lo_c;
  logic [4:0] hi_raw;
  logic [4:0] hi_fix;

  // low digit then high digit, each corrected above nine
  always_comb begin
    lo_raw = {1'b0, src[3:0]} + {1'b0, dst[3:0]} + {4'h0, x_in};
    lo_c   = (lo_raw > 5'h09);
    lo_fix = lo_c ? (lo_raw + 5'h06) : lo_raw;
    hi_raw = {1'b0, src[7:4]} + {1'b0, dst[7:4]} + {4'h0, lo_c};
    carry  = (hi_raw > 5'h09);
    hi_fix = carry ? (hi_raw + 5'h06) : hi_raw;
    sum    = {hi_fix[3:0], lo_fix[3:0]};
  end

endmodule // add_bcd_byte
`default_nettype wire

/* File: logic/add_family_decode_execute.sv */
`timescale 1ns/1ps
`default_nettype none
module add_family_decode_execute (
  input  wire logic        mclk,
  input  wire logic        rstn,
  // decode port from fetch
  input  wire logic        dec_valid,
  input  wire logic [15:0] opword,
  output logic             dec_legal,
  output logic             dec_illegal,
  output add_family_pkg::op_e dec_op,
  output logic [1:0]       dec_size,
  output logic             dec_ea_is_dst,
  output logic             dec_mem_to_mem,
  output logic [2:0]       dec_reg,
  output logic [2:0]       dec_ea_mode,
  output logic [2:0]       dec_ea_reg,
  output logic [1:0]       dec_ext_words,
  // execute port from operand access
  input  wire logic        ex_valid,
  input  wire logic [15:0] ex_opword,
  input  wire logic [31:0] src_operand,
  input  wire logic [31:0] dst_operand,
  input  wire logic [31:0] imm_word_hi,
  input  wire logic [31:0] imm_word_lo,
  input  wire logic [4:0]  flags_in,
  output logic             res_valid,
  output logic [31:0]      result,
  output logic             result_to_areg,
  output logic [4:0]       flags_out,
  output logic             flags_write
);
  import add_family_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // decode fields
  typedef struct packed {
    logic        rs1;
    logic        rs2;
    logic        dv;
    logic        legal;
    logic        illegal;
    op_e         op;
    logic [1:0]  size;
    logic        ea_dst;
    logic        m2m;
    logic [2:0]  rg;
    logic [2:0]  mode;
    logic [2:0]  ereg;
    logic [1:0]  extw;
    logic        rv;
    logic [31:0] res;
    logic        to_areg;
    logic [4:0]  flags;
    logic        fwr;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [3:0] grp;
  logic [2:0] sel;
  logic [2:0] m;
  logic [2:0] r;
  logic       ok_any;
  logic       ok_mem;
  logic       ok_dat;
  logic       rst_s2;

  // field positions of the add group opcode
  assign grp = opword[15:12];
  assign sel = opword[8:6];
  assign m   = opword[5:3];
  assign r   = opword[2:0];

  add_ea_check u_ea (
    .mode        (m),
    .reg_no      (r),
    .ok_any      (ok_any),
    .ok_mem_alt  (ok_mem),
    .ok_data_alt (ok_dat)
  );

  //////////////////////////////////////////////////////////////////////
  // execute datapath

  logic       x_grp_bcd;
  logic       x_grp_imm;
  logic [2:0] x_sel;
  logic [1:0] x_size;
  logic       x_areg;
  logic [7:0] bcd_sum;
  logic       bcd_c;

  // execute recovers the kind from its own copy of the opword
  assign x_grp_bcd = (ex_opword[15:12] == GRP_BCD);
  assign x_grp_imm = (ex_opword[15:12] == GRP_IMM);
  assign x_sel     = ex_opword[8:6];
  assign x_areg    = !x_grp_bcd && !x_grp_imm
                     && (x_sel == SEL_AREG_W || x_sel == SEL_AREG_L);
  assign x_size    = x_grp_imm ? ex_opword[7:6] : x_sel[1:0];

  add_bcd_byte u_bcd (
    .src   (src_operand[7:0]),
    .dst   (dst_operand[7:0]),
    .x_in  (flags_in[FLAG_X]),
    .sum   (bcd_sum),
    .carry (bcd_c)
  );

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [32:0] sum33;
    logic [31:0] a;
    logic [31:0] b;
    logic        cy;
    logic        ov;
    logic        ng;
    logic        zr;
    sum33 = 33'h0_0000_0000;
    a     = 32'h0000_0000;
    b     = 32'h0000_0000;
    cy    = 1'b0;
    ov    = 1'b0;
    ng    = 1'b0;
    zr    = 1'b0;
    st_d  = st_q;

    // decode stage
    st_d.dv      = dec_valid;
    st_d.legal   = 1'b0;
    st_d.illegal = 1'b0;
    st_d.op      = OP_NONE;
    st_d.size    = SZ_BYTE;
    st_d.ea_dst  = 1'b0;
    st_d.m2m     = 1'b0;
    st_d.rg      = opword[11:9];
    st_d.mode    = m;
    st_d.ereg    = r;
    st_d.extw    = 2'h0;
    if (dec_valid) begin
      if (grp == GRP_BCD && opword[8] && opword[7:4] == BCD_ZERO_BITS) begin
        st_d.op    = OP_BCD;
        st_d.size  = SZ_BYTE;
        st_d.m2m   = opword[3];
        st_d.mode  = opword[3] ? EA_PRE : EA_DREG;
        st_d.legal = 1'b1;
      end else if (grp == GRP_ADD) begin
        unique case (sel)
          SEL_EA_TO_REG_B, SEL_EA_TO_REG_W, SEL_EA_TO_REG_L: begin
            st_d.op    = OP_BIN;
            st_d.size  = sel[1:0];
            // address direct only for word and long
            st_d.legal = ok_any && !(m == EA_AREG && sel == SEL_EA_TO_REG_B);
          end
          SEL_REG_TO_EA_B, SEL_REG_TO_EA_W, SEL_REG_TO_EA_L: begin
            st_d.op     = OP_BIN;
            st_d.size   = sel[1:0];
            st_d.ea_dst = 1'b1;
            // data register destination form is invalid here
            st_d.legal  = ok_mem;
          end
          SEL_AREG_W, SEL_AREG_L: begin
            st_d.op    = OP_AREG;
            st_d.size  = (sel == SEL_AREG_W) ? SZ_WORD : SZ_LONG;
            st_d.legal = ok_any;
          end
        endcase
      end else if (grp == GRP_IMM && opword[11:8] == IMM_SUBCODE
                   && opword[7:6] != 2'h3) begin
        st_d.op     = OP_IMM;
        st_d.size   = opword[7:6];
        st_d.ea_dst = 1'b1;
        st_d.extw   = (opword[7:6] == SZ_LONG) ? 2'h2 : 2'h1;
        st_d.legal  = ok_dat;
      end
      st_d.illegal = !st_d.legal;
      if (!st_d.legal) begin
        st_d.op = OP_NONE;
      end
    end

    // execute stage
    st_d.rv      = ex_valid;
    st_d.fwr     = 1'b0;
    st_d.to_areg = 1'b0;
    if (ex_valid) begin
      if (x_grp_bcd) begin
        st_d.res   = {dst_operand[31:8], bcd_sum};
        st_d.flags = flags_in;
        st_d.flags[FLAG_C] = bcd_c;
        st_d.flags[FLAG_X] = bcd_c;
        // zero only ever cleared, n and v left as they were
        if (bcd_sum != 8'h00) begin
          st_d.flags[FLAG_Z] = 1'b0;
        end
        st_d.fwr = 1'b1;
      end else if (x_areg) begin
        // word source sign extended, whole register updated
        a = (x_sel == SEL_AREG_W) ? {{16{src_operand[15]}}, src_operand[15:0]}
                                  : src_operand;
        st_d.res     = a + dst_operand;
        st_d.to_areg = 1'b1;
        st_d.flags   = flags_in;
      end else begin
        // immediate data taken by size from the extension words
        if (x_grp_imm) begin
          unique case (x_size)
            SZ_BYTE: a = {24'h00_0000, imm_word_hi[7:0]};
            SZ_WORD: a = {16'h0000, imm_word_hi[15:0]};
            default: a = {imm_word_hi[15:0], imm_word_lo[15:0]};
          endcase
        end else begin
          a = src_operand;
        end
        b = dst_operand;
        unique case (x_size)
          SZ_BYTE: begin
            sum33 = {25'h0, a[7:0]} + {25'h0, b[7:0]};
            cy = sum33[8];
            ng = sum33[7];
            zr = (sum33[7:0] == 8'h00);
            ov = (a[7] == b[7]) && (sum33[7] != a[7]);
            st_d.res = {b[31:8], sum33[7:0]};
          end
          SZ_WORD: begin
            sum33 = {17'h0, a[15:0]} + {17'h0, b[15:0]};
            cy = sum33[16];
            ng = sum33[15];
            zr = (sum33[15:0] == 16'h0000);
            ov = (a[15] == b[15]) && (sum33[15] != a[15]);
            st_d.res = {b[31:16], sum33[15:0]};
          end
          default: begin
            sum33 = {1'b0, a} + {1'b0, b};
            cy = sum33[32];
            ng = sum33[31];
            zr = (sum33[31:0] == 32'h0000_0000);
            ov = (a[31] == b[31]) && (sum33[31] != a[31]);
            st_d.res = sum33[31:0];
          end
        endcase
        st_d.flags = {cy, ng, zr, ov, cy};
        st_d.fwr   = 1'b1;
      end
    end

    // two flop release of the reset; the rest stays cleared until it ends
    st_d.rs1 = 1'b1;
    st_d.rs2 = st_q.rs1;
    if (!st_q.rs2) begin
      st_d = '{op: OP_NONE, res: RESULT_RESET, flags: FLAGS_RESET, rs1: 1'b1, rs2: st_q.rs1,
               default: '0};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{op: OP_NONE, res: RESULT_RESET, flags: FLAGS_RESET, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign dec_legal      = st_q.dv && st_q.legal;
  assign dec_illegal    = st_q.dv && st_q.illegal;
  assign dec_op         = st_q.op;
  assign dec_size       = st_q.size;
  assign dec_ea_is_dst  = st_q.ea_dst;
  assign dec_mem_to_mem = st_q.m2m;
  assign dec_reg        = st_q.rg;
  assign dec_ea_mode    = st_q.mode;
  assign dec_ea_reg     = st_q.ereg;
  assign dec_ext_words  = st_q.extw;
  assign res_valid      = st_q.rv;
  assign result         = st_q.res;
  assign result_to_areg = st_q.to_areg;
  assign flags_out      = st_q.flags;
  assign flags_write    = st_q.fwr;
  assign rst_s2         = st_q.rs2; // released reset copy

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_bcd_flags;
    @(posedge mclk) disable iff (!rst_s2)
      (ex_valid && x_grp_bcd) |=> (flags_out[FLAG_X] == flags_out[FLAG_C]) && flags_write;
  endproperty
  a_bcd_flags: assert property (p_bcd_flags) else $error("bcd extend differs from carry");
  property p_bcd_zero;
    @(posedge mclk) disable iff (!rst_s2)
      (ex_valid && x_grp_bcd && !flags_in[FLAG_Z]) |=> !flags_out[FLAG_Z];
  endproperty
  a_bcd_zero: assert property (p_bcd_zero) else $error("bcd set zero flag");
  property p_areg_flags;
    @(posedge mclk) disable iff (!rst_s2)
      (ex_valid && x_areg) |=> (flags_out == $past(flags_in)) && !flags_write
                               && result_to_areg;
  endproperty
  a_areg_flags: assert property (p_areg_flags) else $error("address add touched flags");
  property p_bin_xc;
    @(posedge mclk) disable iff (!rst_s2)
      (ex_valid && !x_grp_bcd && !x_areg) |=> flags_out[FLAG_X] == flags_out[FLAG_C];
  endproperty
  a_bin_xc: assert property (p_bin_xc) else $error("binary extend differs from carry");
  property p_bin_zero;
    @(posedge mclk) disable iff (!rst_s2)
      (ex_valid && !x_grp_bcd && !x_areg && x_size == SZ_LONG)
      |=> flags_out[FLAG_Z] == (result == 32'h0000_0000);
  endproperty
  a_bin_zero: assert property (p_bin_zero) else $error("long add zero flag wrong");
  property p_dst_dreg;
    @(posedge mclk) disable iff (!rst_s2)
      (dec_valid && grp == GRP_ADD && sel[2] && sel != SEL_AREG_L && m == EA_DREG)
      |=> dec_illegal;
  endproperty
  a_dst_dreg: assert property (p_dst_dreg) else $error("data register ea destination taken");
  property p_byte_areg;
    @(posedge mclk) disable iff (!rst_s2)
      (dec_valid && grp == GRP_ADD && sel == SEL_EA_TO_REG_B && m == EA_AREG) |=> dec_illegal;
  endproperty
  a_byte_areg: assert property (p_byte_areg) else $error("byte address direct source taken");
  property p_imm_ext;
    @(posedge mclk) disable iff (!rst_s2)
      dec_legal && dec_op == OP_IMM |-> dec_ext_words == ((dec_size == SZ_LONG) ? 2'h2 : 2'h1);
  endproperty
  a_imm_ext: assert property (p_imm_ext) else $error("immediate word count wrong");
  property p_imm_dst;
    @(posedge mclk) disable iff (!rst_s2)
      (dec_valid && grp == GRP_IMM && opword[11:8] == IMM_SUBCODE && m == EA_AREG)
      |=> dec_illegal;
  endproperty
  a_imm_dst: assert property (p_imm_dst) else $error("immediate add to address register");

endmodule // add_family_decode_execute
`default_nettype wire

/* File: verification/fetch_operand_model.sv */
`timescale 1ns/1ps
`default_nettype none
// fetch and operand access side: forwards one request a cycle, scrambles idle lines
module fetch_operand_model (
  input  wire logic        mclk,
  input  wire logic        req,
  input  wire logic        req_ex,
  input  wire logic [15:0] req_op,
  input  wire logic [31:0] req_src,
  input  wire logic [31:0] req_dst,
  input  wire logic [31:0] req_hi,
  input  wire logic [31:0] req_lo,
  input  wire logic [4:0]  req_flg,
  output logic             dec_valid,
  output logic [15:0]      opword,
  output logic             ex_valid,
  output logic [15:0]      ex_opword,
  output logic [31:0]      src_operand,
  output logic [31:0]      dst_operand,
  output logic [31:0]      imm_word_hi,
  output logic [31:0]      imm_word_lo,
  output logic [4:0]       flags_in
);
  logic [31:0] pat_q = 32'h5A5A_C3C3;

  ////////////////////////////////////////////////////////////////////////////
  // idle pattern flips every cycle so stale values never look valid
  always_ff @(posedge mclk) begin
    pat_q <= ~pat_q;
  end

  // requests pass straight through, any opword included; idle lines carry the pattern
  assign dec_valid   = req;
  assign ex_valid    = req_ex;
  assign opword      = req ? req_op : pat_q[15:0];
  assign ex_opword   = req_ex ? req_op : pat_q[31:16];
  assign src_operand = req_ex ? req_src : pat_q;
  assign dst_operand = req_ex ? req_dst : ~pat_q;
  assign imm_word_hi = req_ex ? req_hi : pat_q;
  assign imm_word_lo = req_ex ? req_lo : ~pat_q;
  assign flags_in    = req_ex ? req_flg : pat_q[4:0];
endmodule // fetch_operand_model
`default_nettype wire

/* File: verification/test_add_family_decode_execute.sv */
`timescale 1ns/1ps
`default_nettype none
module test_add_family_decode_execute;
  import add_family_pkg::*;

  typedef struct {
    logic [15:0] op;
    logic [31:0] s, d, h, l;
    logic [4:0]  f;
    logic        lg;
    op_e         k;
    logic [1:0]  sz;
    logic        ed, mm;
    logic [2:0]  rg;
    logic [1:0]  xw;
  } row_s;

  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        req = 1'b0, req_ex = 1'b0;
  logic [15:0] req_op = 16'h0000;
  logic [31:0] req_src = 32'h0, req_dst = 32'h0, req_hi = 32'h0, req_lo = 32'h0;
  logic [4:0]  req_flg = 5'h00;
  logic        dec_valid, ex_valid, dec_legal, dec_illegal, dec_ea_is_dst, dec_mem_to_mem;
  logic [15:0] opword, ex_opword;
  logic [31:0] src_operand, dst_operand, imm_word_hi, imm_word_lo, result;
  logic [4:0]  flags_in, flags_out;
  op_e         dec_op;
  logic [1:0]  dec_size, dec_ext_words;
  logic [2:0]  dec_reg, dec_ea_mode, dec_ea_reg;
  logic        res_valid, result_to_areg, flags_write;
  int          error_cnt = 0;
  int          check_count = 0;
  row_s        rows[23];

  ////////////////////////////////////////////////////////////////////////////
  // clock
  always #12.5 mclk = ~mclk;

  fetch_operand_model fetch_model (.mclk(mclk), .req(req), .req_ex(req_ex), .req_op(req_op),
    .req_src(req_src), .req_dst(req_dst), .req_hi(req_hi), .req_lo(req_lo),
    .req_flg(req_flg), .dec_valid(dec_valid), .opword(opword), .ex_valid(ex_valid),
    .ex_opword(ex_opword), .src_operand(src_operand), .dst_operand(dst_operand),
    .imm_word_hi(imm_word_hi), .imm_word_lo(imm_word_lo), .flags_in(flags_in));

  add_family_decode_execute uut (.mclk(mclk), .rstn(rstn), .dec_valid(dec_valid),
    .opword(opword), .dec_legal(dec_legal), .dec_illegal(dec_illegal), .dec_op(dec_op),
    .dec_size(dec_size), .dec_ea_is_dst(dec_ea_is_dst), .dec_mem_to_mem(dec_mem_to_mem),
    .dec_reg(dec_reg), .dec_ea_mode(dec_ea_mode), .dec_ea_reg(dec_ea_reg),
    .dec_ext_words(dec_ext_words), .ex_valid(ex_valid), .ex_opword(ex_opword),
    .src_operand(src_operand), .dst_operand(dst_operand), .imm_word_hi(imm_word_hi),
    .imm_word_lo(imm_word_lo), .flags_in(flags_in), .res_valid(res_valid),
    .result(result), .result_to_areg(result_to_areg), .flags_out(flags_out),
    .flags_write(flags_write));

  ////////////////////////////////////////////////////////////////////////////
  // expected execute outputs: {to_areg, flag_write, flags, result}
  function automatic logic [38:0] model_ex(input row_s r);
    logic [31:0] m, a, res;
    logic [32:0] t;
    logic [4:0]  lo, hi, fl;
    int          w;
    fl = r.f;
    if (r.op[15:12] == GRP_BCD) begin
      lo = {1'b0, r.s[3:0]} + r.d[3:0] + r.f[FLAG_X];
      if (lo > 5'h09) lo = lo + 5'h06;
      hi = {1'b0, r.s[7:4]} + r.d[7:4] + lo[4];
      if (hi > 5'h09) hi = hi + 5'h06;
      res = {r.d[31:8], hi[3:0], lo[3:0]};
      fl[FLAG_X] = hi[4];
      fl[FLAG_C] = hi[4];
      if (res[7:0] != 8'h00) fl[FLAG_Z] = 1'b0;
      return {1'b0, 1'b1, fl, res};
    end
    if (r.op[15:12] == GRP_ADD && r.op[7:6] == 2'h3) begin
      a = r.op[8] ? r.s : {{16{r.s[15]}}, r.s[15:0]};
      return {1'b1, 1'b0, r.f, r.d + a};
    end
    a = r.s;
    if (r.op[15:12] == GRP_IMM) begin
      a = (r.op[7:6] == SZ_BYTE) ? {24'h0, r.h[7:0]} :
          (r.op[7:6] == SZ_WORD) ? {16'h0, r.h[15:0]} : {r.h[15:0], r.l[15:0]};
    end
    w = 8 << r.op[7:6];
    m = 32'hFFFF_FFFF >> (32 - w);
    t = {1'b0, r.d & m} + {1'b0, a & m};
    res = (r.d & ~m) | (t[31:0] & m);
    fl = {t[w], t[w-1], (t[31:0] & m) == 32'h0,
          (a[w-1] == r.d[w-1]) && (t[w-1] != r.d[w-1]), t[w]};
    return {1'b0, 1'b1, fl, res};
  endfunction

  // an illegal opword row
  function automatic row_s bad(input logic [15:0] op);
    return '{op, 32'h0, 32'h0, 32'h0, 32'h0, 5'h00, 1'b0, OP_NONE, 2'h0, 1'b0, 1'b0, 3'h0, 2'h0};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic drive_row(input row_s r, input logic on);
    req     <= on;
    req_ex  <= on & r.lg;
    req_op  <= r.op;
    req_src <= r.s;
    req_dst <= r.d;
    req_hi  <= r.h;
    req_lo  <= r.l;
    req_flg <= r.f;
  endtask

  // compares both answers of one request
  task automatic check_row(input row_s r);
    logic [38:0] e;
    e = model_ex(r);
    check(dec_legal, r.lg);
    check(dec_illegal, !r.lg);
    check(dec_op, r.k);
    check(res_valid, r.lg);
    if (r.lg) begin
      check(dec_size, r.sz);
      check(dec_reg, r.rg);
      check(dec_ext_words, r.xw);
      check(dec_ea_reg, r.op[2:0]);
      check(dec_mem_to_mem, r.mm);
      check(dec_ea_is_dst, r.ed);
      if (r.k == OP_BCD) begin
        check(dec_ea_mode, r.mm ? EA_PRE : EA_DREG);
      end else begin
        check(dec_ea_mode, r.op[5:3]);
      end
      check(result, e[31:0]);
      check(result_to_areg, e[38]);
      check(flags_write, e[37]);
      check(flags_out, e[36:32]);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #(25 * 400);
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial begin
    rows = '{
      '{16'hD040, 32'h80, 32'h1234_FF80, 32'h0, 32'h0, 5'h00, 1'b1, OP_BIN, 2'h1, 0, 0, 3'h0, 2'h0},
      bad(16'hD008),
      '{16'hD648, 32'h7FFF, 32'h1, 32'h0, 32'h0, 5'h00, 1'b1, OP_BIN, 2'h1, 0, 0, 3'h3, 2'h0},
      '{16'hD0BC, 32'hFFFF_FFFF, 32'h1, 32'h0, 32'h0, 5'h1F, 1'b1, OP_BIN, 2'h2, 0, 0, 3'h0, 2'h0},
      '{16'hD110, 32'h7F, 32'hABCD_EF01, 32'h0, 32'h0, 5'h00, 1'b1, OP_BIN, 2'h0, 1, 0, 3'h0, 2'h0},
      '{16'hD150, 32'h1, 32'hFFFF, 32'h0, 32'h0, 5'h00, 1'b1, OP_BIN, 2'h1, 1, 0, 3'h0, 2'h0},
      bad(16'hD1BA),
      '{16'hD1B9, 32'h8000_0000, 32'h8000_0000, 32'h0, 32'h0, 5'h00, 1'b1, OP_BIN, 2'h2, 1, 0,
        3'h0, 2'h0},
      '{16'hD0C9, 32'h8000, 32'h1_0000, 32'h0, 32'h0, 5'h1F, 1'b1, OP_AREG, 2'h1, 0, 0, 3'h0, 2'h0},
      '{16'hDFFC, 32'h1, 32'hFFFF_FFFF, 32'h0, 32'h0, 5'h00, 1'b1, OP_AREG, 2'h2, 0, 0, 3'h7, 2'h0},
      '{16'hD000, 32'hFF, 32'h5555_5501, 32'h0, 32'h0, 5'h00, 1'b1, OP_BIN, 2'h0, 0, 0, 3'h0, 2'h0},
      '{16'hC101, 32'h09, 32'hAB01, 32'h0, 32'h0, 5'h00, 1'b1, OP_BCD, 2'h0, 0, 0, 3'h0, 2'h0},
      // zero preset before a chain, kept on a zero result
      '{16'hC109, 32'h50, 32'h50, 32'h0, 32'h0, 5'h0E, 1'b1, OP_BCD, 2'h0, 0, 1, 3'h0, 2'h0},
      '{16'hCF01, 32'h99, 32'h99, 32'h0, 32'h0, 5'h14, 1'b1, OP_BCD, 2'h0, 0, 0, 3'h7, 2'h0},
      bad(16'hC111),
      '{16'h0640, 32'h1234_5678, 32'h1, 32'hFFFF, 32'h0, 5'h00, 1'b1, OP_IMM, 2'h1, 1, 0, 3'h3,
        2'h1},
      '{16'h0690, 32'h0, 32'h1, 32'h1234, 32'h5678, 5'h00, 1'b1, OP_IMM, 2'h2, 1, 0, 3'h3, 2'h2},
      '{16'h0610, 32'h0, 32'h1, 32'hAB_CD7F, 32'h0, 5'h00, 1'b1, OP_IMM, 2'h0, 1, 0, 3'h3, 2'h1},
      bad(16'h0608), bad(16'h06C0), bad(16'h4E71),
      bad(16'hD101), bad(16'hD03D)};
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(dec_op, OP_NONE);
    // back-to-back requests, one answer checked per cycle
    for (int i = 0; i <= 22; i++) begin
      @(posedge mclk);
      drive_row(rows[i], 1'b1);
      if (i > 0) begin
        @(negedge mclk);
        check_row(rows[i - 1]);
      end
    end
    @(posedge mclk);
    @(negedge mclk);
    check_row(rows[22]);
    // reset in mid-run with a request in flight, then held through release
    @(posedge mclk);
    drive_row(rows[0], 1'b1);
    @(posedge mclk);
    rstn <= 1'b0;
    @(negedge mclk);
    check(res_valid, 1'b0);
    check(dec_op, OP_NONE);
    check(result, RESULT_RESET);
    check(flags_out, FLAGS_RESET);
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(dec_legal, 1'b0);
    @(posedge mclk);
    @(negedge mclk);
    check_row(rows[0]);
    wrap_up();
  end
endmodule // test_add_family_decode_execute
`default_nettype wire
